// >>> rtl/tic_defs.svh
`ifndef TIC_DEFS_SVH
`define TIC_DEFS_SVH
// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define TIC_ADDR_CORE_CONTROL 8'h00
`define TIC_ADDR_INT_CTRL_ONE 8'h04
`define TIC_ADDR_INT_CTRL_TWO 8'h08
`define TIC_ADDR_INT_FLAGS_ZERO 8'h0c
`define TIC_ADDR_STATUS_WORD 8'h10
`define TIC_ADDR_SHADOW 8'h14
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TIC_CORE_PRIO_MSB 3
`define TIC_STATUS_PRIO_LO 7
`define TIC_STATUS_PRIO_HI 5
`define TIC_ONE_NEST_DIS 15
`define TIC_ONE_OVA_FLAG 14
`define TIC_ONE_OVB_FLAG 13
`define TIC_ONE_COVA_FLAG 12
`define TIC_ONE_COVB_FLAG 11
`define TIC_ONE_OVA_TE 10
`define TIC_ONE_OVB_TE 9
`define TIC_ONE_COV_TE 8
`define TIC_ONE_SHIFT_FLAG 7
`define TIC_ONE_DIV0_FLAG 6
`define TIC_ONE_DMA_FLAG 5
`define TIC_ONE_MATH_FLAG 4
`define TIC_ONE_ADDR_FLAG 3
`define TIC_ONE_STACK_FLAG 2
`define TIC_ONE_OSC_FLAG 1
`define TIC_TWO_ALT_TABLE 15
`define TIC_TWO_IRQ_DISABLE_INSN_ACTIVE 14
`define TIC_NUM_EXT 5
// ------------------------------------------------------------
// masks and reset values
// ------------------------------------------------------------
`define TIC_ONE_WR_MASK 16'hfffe
`define TIC_TWO_WR_MASK 16'h801f
`define TIC_FLAGS_MASK 16'h7fff
`define TIC_RST_16 16'h0000
`define TIC_RST_3 3'h0
`define TIC_PRIO_MAX_LO 3'h7
`endif

// >>> rtl/tic_pkg.sv
package tic_pkg;
  typedef enum logic [2:0] {
    TIC_IDLE = 3'b001,
    TIC_SETUP = 3'b010,
    TIC_ACCESS = 3'b100
  } tic_apb_state_e;
  typedef logic [15:0] tic_word_t;
endpackage

// >>> rtl/tic_edge_detect.sv
`timescale 1ns/10ps
`default_nettype none
`include "tic_defs.svh"
// ------------------------------------------------------------
// synchronised edge detector, one per external input
// ------------------------------------------------------------
module tic_edge_detect #(
  parameter int N = `TIC_NUM_EXT
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [N-1:0] pin_i,
  input wire logic [N-1:0] neg_sel_i,
  output logic [N-1:0] edge_o
);
  logic [N-1:0] sync1_r;
  logic [N-1:0] sync2_r;
  logic [N-1:0] last_r;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
      last_r <= '0;
    end else begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
      last_r <= sync2_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_edge
      // falling when polarity set, rising otherwise
      assign edge_o[g] = neg_sel_i[g] ? (last_r[g] & ~sync2_r[g]) :
                                        (~last_r[g] & sync2_r[g]);
    end
  endgenerate
endmodule
`default_nettype wire

// >>> rtl/tic_top.sv
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "tic_defs.svh"
module tic_top (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trap_taken_i,
  input wire logic trap_return_i,
  input wire logic acc_a_ovf_i,
  input wire logic acc_b_ovf_i,
  input wire logic acc_a_cat_i,
  input wire logic acc_b_cat_i,
  input wire logic bad_shift_i,
  input wire logic divide_zero_i,
  input wire logic dma_err_i,
  input wire logic address_err_i,
  input wire logic stack_err_i,
  input wire logic osc_fail_i,
  input wire logic irq_disable_insn_active_active_i,
  input wire logic [4:0] ext_irq_pin_i,
  input wire logic [13:0] periph_req_i,
  output logic [3:0] cpu_priority_o,
  output logic user_irq_masked_o,
  output logic nesting_disable_o,
  output logic alternate_table_select_o,
  output logic trap_req_o,
  output logic [15:0] flags_zero_o
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  tic_pkg::tic_apb_state_e apb_st_r;
  tic_pkg::tic_word_t one_r;
  tic_pkg::tic_word_t two_r;
  tic_pkg::tic_word_t flags_r;
  tic_pkg::tic_word_t flags_nxt;
  tic_pkg::tic_word_t one_nxt;
  logic priority_level_msb_r;
  logic [2:0] cpu_priority_low_bits_r;
  logic [2:0] saved_low_r;
  logic irq_disable_insn_active_r;
  logic [1:0] irq_disable_insn_active_sync_r;
  logic [4:0] ext_edge;
  logic [13:0] req_sync1_r;
  logic [13:0] req_sync2_r;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic ovf_a_trap;
  logic ovf_b_trap;
  logic cat_trap;
  logic math_trap;
  logic any_trap;
  logic [5:0] trap_sync1_r;
  logic [5:0] trap_sync2_r;
  logic [3:0] ovf_sync1_r;
  logic [3:0] ovf_sync2_r;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `TIC_ADDR_CORE_CONTROL) || (a == `TIC_ADDR_INT_CTRL_ONE) ||
               (a == `TIC_ADDR_INT_CTRL_TWO) || (a == `TIC_ADDR_INT_FLAGS_ZERO) ||
               (a == `TIC_ADDR_STATUS_WORD);
  endfunction

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      trap_sync1_r <= '0;
      trap_sync2_r <= '0;
      ovf_sync1_r <= '0;
      ovf_sync2_r <= '0;
      req_sync1_r <= '0;
      req_sync2_r <= '0;
      irq_disable_insn_active_sync_r <= '0;
    end else begin
      trap_sync1_r <= {bad_shift_i, divide_zero_i, dma_err_i, address_err_i,
                       stack_err_i, osc_fail_i};
      trap_sync2_r <= trap_sync1_r;
      ovf_sync1_r <= {acc_a_ovf_i, acc_b_ovf_i, acc_a_cat_i, acc_b_cat_i};
      ovf_sync2_r <= ovf_sync1_r;
      req_sync1_r <= periph_req_i;
      req_sync2_r <= req_sync1_r;
      irq_disable_insn_active_sync_r <= {irq_disable_insn_active_sync_r[0], irq_disable_insn_active_active_i};
    end
  end

  tic_edge_detect #(
    .N(`TIC_NUM_EXT)
  ) u_edge (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(ext_irq_pin_i),
    .neg_sel_i(two_r[`TIC_NUM_EXT-1:0]),
    .edge_o(ext_edge)
  );

  // ------------------------------------------------------------
  // trap qualification
  // ------------------------------------------------------------
  assign ovf_a_trap = ovf_sync2_r[3] & one_r[`TIC_ONE_OVA_TE];
  assign ovf_b_trap = ovf_sync2_r[2] & one_r[`TIC_ONE_OVB_TE];
  assign cat_trap = (ovf_sync2_r[1] | ovf_sync2_r[0]) & one_r[`TIC_ONE_COV_TE];
  assign math_trap = ovf_a_trap | ovf_b_trap | cat_trap | trap_sync2_r[5] |
                     trap_sync2_r[4];
  assign any_trap = math_trap | (|trap_sync2_r[3:0]);

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  assign addr_ok = addr_hit(paddr);
  assign wr_en = (apb_st_r == tic_pkg::TIC_ACCESS) && pwrite && addr_ok;
  assign rd_en = (apb_st_r == tic_pkg::TIC_SETUP) && !pwrite;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      apb_st_r <= tic_pkg::TIC_IDLE;
    end else begin
      case (apb_st_r)
        tic_pkg::TIC_IDLE: begin
          if (psel && !penable) begin
            apb_st_r <= tic_pkg::TIC_SETUP;
          end
        end
        tic_pkg::TIC_SETUP: begin
          apb_st_r <= tic_pkg::TIC_ACCESS;
        end
        tic_pkg::TIC_ACCESS: begin
          apb_st_r <= tic_pkg::TIC_IDLE;
        end
        default: begin
          apb_st_r <= tic_pkg::TIC_IDLE;
        end
      endcase
    end
  end

  // ready and error registered one cycle into access phase
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= (apb_st_r == tic_pkg::TIC_SETUP);
      pslverr <= (apb_st_r == tic_pkg::TIC_SETUP) && !addr_ok;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata <= '0;
    end else if (rd_en) begin
      case (paddr)
        `TIC_ADDR_CORE_CONTROL: begin
          prdata <= 32'(priority_level_msb_r) << `TIC_CORE_PRIO_MSB;
        end
        `TIC_ADDR_INT_CTRL_ONE: begin
          prdata <= {16'h0000, one_r & `TIC_ONE_WR_MASK};
        end
        `TIC_ADDR_INT_CTRL_TWO: begin
          prdata <= {16'h0000, (two_r & `TIC_TWO_WR_MASK) |
                     (16'(irq_disable_insn_active_r) << `TIC_TWO_IRQ_DISABLE_INSN_ACTIVE)};
        end
        `TIC_ADDR_INT_FLAGS_ZERO: begin
          prdata <= {16'h0000, flags_r & `TIC_FLAGS_MASK};
        end
        `TIC_ADDR_STATUS_WORD: begin
          prdata <= 32'(cpu_priority_low_bits_r) << `TIC_STATUS_PRIO_HI;
        end
        default: begin
          prdata <= '0;
        end
      endcase
    end else begin
      prdata <= '0;
    end
  end

  // ------------------------------------------------------------
  // interrupt control one: enables, trap flags
  // ------------------------------------------------------------
  always_comb begin
    one_nxt = one_r;
    if (wr_en && paddr == `TIC_ADDR_INT_CTRL_ONE) begin
      one_nxt = pwdata[15:0] & `TIC_ONE_WR_MASK;
    end
    // hardware sets win over a software clear
    if (ovf_a_trap) one_nxt[`TIC_ONE_OVA_FLAG] = 1'b1;
    if (ovf_b_trap) one_nxt[`TIC_ONE_OVB_FLAG] = 1'b1;
    if (ovf_sync2_r[1] && one_r[`TIC_ONE_COV_TE]) one_nxt[`TIC_ONE_COVA_FLAG] = 1'b1;
    if (ovf_sync2_r[0] && one_r[`TIC_ONE_COV_TE]) one_nxt[`TIC_ONE_COVB_FLAG] = 1'b1;
    if (trap_sync2_r[5]) one_nxt[`TIC_ONE_SHIFT_FLAG] = 1'b1;
    if (trap_sync2_r[4]) one_nxt[`TIC_ONE_DIV0_FLAG] = 1'b1;
    if (trap_sync2_r[3]) one_nxt[`TIC_ONE_DMA_FLAG] = 1'b1;
    if (math_trap) one_nxt[`TIC_ONE_MATH_FLAG] = 1'b1;
    if (trap_sync2_r[2]) one_nxt[`TIC_ONE_ADDR_FLAG] = 1'b1;
    if (trap_sync2_r[1]) one_nxt[`TIC_ONE_STACK_FLAG] = 1'b1;
    if (trap_sync2_r[0]) one_nxt[`TIC_ONE_OSC_FLAG] = 1'b1;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      one_r <= `TIC_RST_16;
    end else begin
      one_r <= one_nxt;
    end
  end

  // ------------------------------------------------------------
  // interrupt control two: table select, polarities
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      two_r <= `TIC_RST_16;
    end else if (wr_en && paddr == `TIC_ADDR_INT_CTRL_TWO) begin
      two_r <= pwdata[15:0] & `TIC_TWO_WR_MASK;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_disable_insn_active_r <= 1'b0;
    end else begin
      irq_disable_insn_active_r <= irq_disable_insn_active_sync_r[1];
    end
  end

  // ------------------------------------------------------------
  // interrupt flags zero
  // ------------------------------------------------------------
  always_comb begin
    flags_nxt = flags_r;
    if (wr_en && paddr == `TIC_ADDR_INT_FLAGS_ZERO) begin
      flags_nxt = pwdata[15:0] & `TIC_FLAGS_MASK;
    end
    // sources set and hold; set wins over clear
    flags_nxt[14:1] = flags_nxt[14:1] | req_sync2_r;
    flags_nxt[0] = flags_nxt[0] | ext_edge[0];
    flags_nxt[15] = 1'b0;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flags_r <= `TIC_RST_16;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ------------------------------------------------------------
  // cpu priority level
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      priority_level_msb_r <= 1'b0;
      saved_low_r <= `TIC_RST_3;
    end else if (trap_taken_i || any_trap) begin
      // not software writable, so traps cannot be masked
      priority_level_msb_r <= 1'b1;
      if (!priority_level_msb_r) begin
        saved_low_r <= cpu_priority_low_bits_r;
      end
    end else if (trap_return_i) begin
      priority_level_msb_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cpu_priority_low_bits_r <= `TIC_RST_3;
    end else if (trap_return_i && priority_level_msb_r) begin
      cpu_priority_low_bits_r <= saved_low_r;
    end else if (wr_en && paddr == `TIC_ADDR_STATUS_WORD &&
                 !one_r[`TIC_ONE_NEST_DIS]) begin
      cpu_priority_low_bits_r <=
        pwdata[`TIC_STATUS_PRIO_LO:`TIC_STATUS_PRIO_HI];
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cpu_priority_o <= '0;
      user_irq_masked_o <= 1'b0;
      nesting_disable_o <= 1'b0;
      alternate_table_select_o <= 1'b0;
      trap_req_o <= 1'b0;
      flags_zero_o <= '0;
    end else begin
      cpu_priority_o <= {priority_level_msb_r, cpu_priority_low_bits_r};
      user_irq_masked_o <= priority_level_msb_r ||
                           (cpu_priority_low_bits_r == `TIC_PRIO_MAX_LO);
      nesting_disable_o <= one_r[`TIC_ONE_NEST_DIS];
      alternate_table_select_o <= two_r[`TIC_TWO_ALT_TABLE];
      trap_req_o <= any_trap;
      flags_zero_o <= flags_r;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_prio_msb;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      1'b1 |=> cpu_priority_o[3] == $past(priority_level_msb_r);
  endproperty
  a_prio_msb: assert property (p_prio_msb) else $error("priority msb mismatch");

  property p_prio_cat;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      1'b1 |=> cpu_priority_o[2:0] == $past(cpu_priority_low_bits_r);
  endproperty
  a_prio_cat: assert property (p_prio_cat) else $error("priority low bits mismatch");

  property p_nest_out;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      $rose(one_r[`TIC_ONE_NEST_DIS]) |=> nesting_disable_o;
  endproperty
  a_nest_out: assert property (p_nest_out) else $error("nesting disable not shown");

  property p_ova_flag;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      ovf_a_trap |=> one_r[`TIC_ONE_OVA_FLAG] && trap_req_o;
  endproperty
  a_ova_flag: assert property (p_ova_flag) else $error("overflow a flag missed");

  property p_ovf_gate;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      !one_r[`TIC_ONE_OVA_TE] && !one_r[`TIC_ONE_OVA_FLAG] &&
      !(wr_en && paddr == `TIC_ADDR_INT_CTRL_ONE) |=> !one_r[`TIC_ONE_OVA_FLAG];
  endproperty
  a_ovf_gate: assert property (p_ovf_gate) else $error("disabled overflow trapped");

  property p_math_flag;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      trap_sync2_r[4] |=> one_r[`TIC_ONE_DIV0_FLAG] && one_r[`TIC_ONE_MATH_FLAG];
  endproperty
  a_math_flag: assert property (p_math_flag) else $error("divide flags missed");

  property p_flag_sticky;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      flags_r[3] && !(wr_en && paddr == `TIC_ADDR_INT_FLAGS_ZERO) |=> flags_r[3];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

  property p_flag15;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      !flags_r[15] && !one_r[0];
  endproperty
  a_flag15: assert property (p_flag15) else $error("reserved bit set");

  property p_low_lock;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      one_r[`TIC_ONE_NEST_DIS] && !trap_return_i |=>
        $stable(cpu_priority_low_bits_r);
  endproperty
  a_low_lock: assert property (p_low_lock) else $error("low bits changed while locked");
endmodule
`default_nettype wire

// >>> verification/tic_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// core and peripheral trap sources
// ------------------------------------------------------------
// event codes: 0 acc a ovf, 1 acc b ovf, 2 acc a cat, 3 acc b cat,
// 4 bad shift, 5 divide zero, 6 dma, 7 address, 8 stack, 9 osc,
// 10 trap taken, 11 trap return
module tic_core_model (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic go_i,
  input wire logic [3:0] sel_i,
  output logic [11:0] ev_o
);
  // one-cycle event on the selected line, low otherwise
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ev_o <= 12'h000;
    end else if (go_i) begin
      ev_o <= 12'h001 << sel_i;
    end else begin
      ev_o <= 12'h000;
    end
  end
endmodule
`default_nettype wire

// >>> verification/trap_and_interrupt_control_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "tic_defs.svh"
module trap_and_interrupt_control_test;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic go = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [11:0] ev;
  logic irq_disable_insn_active = 1'b0;
  logic [4:0] pins = 5'h00;
  logic [13:0] preq = 14'h0000;
  logic [3:0] prio;
  logic masked;
  logic nest;
  logic alt;
  logic trapq;
  logic [15:0] flags;
  logic [31:0] rq;
  logic re;
  int bad_count = 0;
  int n_checks = 0;
  int n_traps = 0;
  logic [15:0] trap_exp [10] = '{16'h4010, 16'h2010, 16'h1010, 16'h0810, 16'h0090,
    16'h0050, 16'h0020, 16'h0008, 16'h0004, 16'h0002};

  always #12.5 clk_sys_i = ~clk_sys_i;

  // counts one-cycle trap request pulses
  always @(posedge clk_sys_i) begin
    if (trapq === 1'b1) begin
      n_traps <= n_traps + 1;
    end
  end

  tic_core_model i_core (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .go_i(go),
    .sel_i(sel), .ev_o(ev));

  tic_top i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trap_taken_i(ev[10]), .trap_return_i(ev[11]),
    .acc_a_ovf_i(ev[0]), .acc_b_ovf_i(ev[1]), .acc_a_cat_i(ev[2]), .acc_b_cat_i(ev[3]),
    .bad_shift_i(ev[4]), .divide_zero_i(ev[5]), .dma_err_i(ev[6]),
    .address_err_i(ev[7]), .stack_err_i(ev[8]), .osc_fail_i(ev[9]),
    .irq_disable_insn_active_active_i(irq_disable_insn_active), .ext_irq_pin_i(pins), .periph_req_i(preq),
    .cpu_priority_o(prio), .user_irq_masked_o(masked), .nesting_disable_o(nest),
    .alternate_table_select_o(alt), .trap_req_o(trapq), .flags_zero_o(flags));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    // wait for ready at a rising edge; only the watchdog ends a hang
    do begin
      @(posedge clk_sys_i);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rq, exp);
  endtask

  task settle;
    repeat (6) @(posedge clk_sys_i);
  endtask

  task ev_pulse(input logic [3:0] c);
    @(posedge clk_sys_i);
    go <= 1'b1;
    sel <= c;
    @(posedge clk_sys_i);
    go <= 1'b0;
    settle();
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_reset;
    rdc(`TIC_ADDR_CORE_CONTROL, 32'h00000000);
    rdc(`TIC_ADDR_INT_CTRL_ONE, 32'h00000000);
    rdc(`TIC_ADDR_INT_CTRL_TWO, 32'h00000000);
    rdc(`TIC_ADDR_INT_FLAGS_ZERO, 32'h00000000);
    chk({28'h0000000, prio}, 32'h00000000);
  endtask

  task t_traps;
    wr(`TIC_ADDR_INT_CTRL_ONE, 32'h00000000);
    ev_pulse(4'h0);
    ev_pulse(4'h2);
    rdc(`TIC_ADDR_INT_CTRL_ONE, 32'h00000000);
    for (int i = 0; i < 10; i++) begin
      wr(`TIC_ADDR_INT_CTRL_ONE, 32'h00000700);
      ev_pulse(i[3:0]);
      rdc(`TIC_ADDR_INT_CTRL_ONE, {16'h0000, trap_exp[i] | 16'h0700});
    end
    chk(n_traps, 32'h0000000a);
    rdc(`TIC_ADDR_CORE_CONTROL, 32'h00000008);
    ev_pulse(4'hb);
    rdc(`TIC_ADDR_CORE_CONTROL, 32'h00000000);
    wr(`TIC_ADDR_INT_CTRL_ONE, 32'h0000ffff);
    rdc(`TIC_ADDR_INT_CTRL_ONE, 32'h0000fffe);
    chk({31'h00000000, nest}, 32'h00000001);
    wr(`TIC_ADDR_INT_CTRL_ONE, 32'h00000000);
  endtask

  task t_ctrl_two;
    irq_disable_insn_active <= 1'b1;
    settle();
    rdc(`TIC_ADDR_INT_CTRL_TWO, 32'h00004000);
    wr(`TIC_ADDR_INT_CTRL_TWO, 32'h0000bfff);
    rdc(`TIC_ADDR_INT_CTRL_TWO, 32'h0000c01f);
    chk({31'h00000000, alt}, 32'h00000001);
    irq_disable_insn_active <= 1'b0;
    wr(`TIC_ADDR_INT_CTRL_TWO, 32'h00004000);
    settle();
    rdc(`TIC_ADDR_INT_CTRL_TWO, 32'h00000000);
  endtask

  task t_ext;
    pins <= 5'h01;
    settle();
    rdc(`TIC_ADDR_INT_FLAGS_ZERO, 32'h00000001);
    wr(`TIC_ADDR_INT_FLAGS_ZERO, 32'h00000000);
    wr(`TIC_ADDR_INT_CTRL_TWO, 32'h00000001);
    pins <= 5'h00;
    settle();
    rdc(`TIC_ADDR_INT_FLAGS_ZERO, 32'h00000001);
    wr(`TIC_ADDR_INT_FLAGS_ZERO, 32'h00000000);
    pins <= 5'h01;
    settle();
    rdc(`TIC_ADDR_INT_FLAGS_ZERO, 32'h00000000);
  endtask

  task t_flags;
    for (int i = 0; i < 14; i++) begin
      @(posedge clk_sys_i);
      preq <= 14'h0001 << i;
      @(posedge clk_sys_i);
      preq <= 14'h0000;
      settle();
      rdc(`TIC_ADDR_INT_FLAGS_ZERO, 32'h00000002 << i);
      chk({16'h0000, flags}, 32'h00000002 << i);
      wr(`TIC_ADDR_INT_FLAGS_ZERO, 32'h00000000);
    end
    rdc(`TIC_ADDR_INT_FLAGS_ZERO, 32'h00000000);
    wr(`TIC_ADDR_INT_FLAGS_ZERO, 32'h0000ffff);
    rdc(`TIC_ADDR_INT_FLAGS_ZERO, 32'h00007fff);
    wr(`TIC_ADDR_INT_FLAGS_ZERO, 32'h00000000);
  endtask

  task t_prio;
    wr(`TIC_ADDR_STATUS_WORD, 32'h00000040);
    settle();
    chk({27'h0000000, masked, prio}, 32'h00000002);
    wr(`TIC_ADDR_STATUS_WORD, 32'h000000e0);
    settle();
    chk({27'h0000000, masked, prio}, 32'h00000017);
    ev_pulse(4'ha);
    rdc(`TIC_ADDR_CORE_CONTROL, 32'h00000008);
    chk({27'h0000000, masked, prio}, 32'h0000001f);
    wr(`TIC_ADDR_CORE_CONTROL, 32'h00000000);
    rdc(`TIC_ADDR_CORE_CONTROL, 32'h00000008);
    ev_pulse(4'hb);
    rdc(`TIC_ADDR_CORE_CONTROL, 32'h00000000);
    chk({28'h0000000, prio}, 32'h00000007);
    wr(`TIC_ADDR_INT_CTRL_ONE, 32'h00008000);
    wr(`TIC_ADDR_STATUS_WORD, 32'h00000020);
    rdc(`TIC_ADDR_STATUS_WORD, 32'h000000e0);
    wr(`TIC_ADDR_INT_CTRL_ONE, 32'h00000000);
    wr(`TIC_ADDR_STATUS_WORD, 32'h00000000);
    rdc(`TIC_ADDR_STATUS_WORD, 32'h00000000);
    rdc(8'h18, 32'h00000000);
    chk({31'h00000000, re}, 32'h00000001);
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_traps();
    t_ctrl_two();
    t_ext();
    t_flags();
    t_prio();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
